/* File: csma_addr_filter_config_regs.sv */
// configuration registers for csma-ca, auto receive, address filter
// assumes an axi4-lite master on aclk; engines sit outside the block
//
// Contract
// - timeout select picks timeout auto receive, only while auto receive mode 0 is enabled
// - zero floor skips cca unless select set
// - unicast value applies only when enabled
// - network identifier compared, resets all ones
// - short address compared, resets all ones
// - backoff window register resets to 0x20
// - exponent register resets to 0x05
// - unicast value bit sits in csma register 0
`timescale 1ns/100ps
module csma_addr_filter_config_regs
  import csma_cfg_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int EXP_W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [EXP_W-1:0] backoff_exp_floor,
  input wire logic csma_done,
  input wire logic auto_rx_mode0_en,
  output logic rx_timeout_active,
  output logic cca_required,
  output csma_param_t csma_param,
  output filter_cfg_t filter_cfg
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // offsets up to 0x21 times four need eight address bits
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end
  if (EXP_W < 1 || EXP_W > 4) begin : g_bad_exp
    $error("EXP_W must be 1 to 4");
  end

  // ************************************************************
  // write channel capture
  // ************************************************************
  logic aw_held_reg; // write address taken, waiting for data
  logic w_held_reg; // write data taken, waiting for address
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  bus_phase_t rd_phase_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // channels accepted independently, stalled while a response waits
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_reg || aw_fire;
  wire w_have = w_held_reg || w_fire;
  wire wr_go = aw_have && w_have;
  wire [ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  // word index; low two bits of byte address are ignored
  wire [15:0] wr_idx = 16'(wr_addr[ADDR_W-1:2]);
  wire wr_lane0 = wr_go && wr_strb[0];

  // ************************************************************
  // write decode
  // ************************************************************
  wire we_timeout = wr_lane0 && (wr_idx == `IDX_TIMEOUT_MODE);
  wire we_win = wr_lane0 && (wr_idx == `IDX_BACKOFF_WIN);
  wire we_exp = wr_lane0 && (wr_idx == `IDX_EXP_UNICAST);
  wire we_csma0 = wr_lane0 && (wr_idx == `IDX_UNICAST_VAL);
  wire we_short_lo = wr_lane0 && (wr_idx == `IDX_SHORT_LO);
  wire we_short_hi = wr_lane0 && (wr_idx == `IDX_SHORT_HI);
  wire we_net_lo = wr_lane0 && (wr_idx == `IDX_NETID_LO);
  wire we_net_hi = wr_lane0 && (wr_idx == `IDX_NETID_HI);
  wire we_ctrl = wr_lane0 && (wr_idx == `IDX_CTRL);
  wire wr_mapped = (wr_idx == `IDX_TIMEOUT_MODE) ||
    (wr_idx == `IDX_BACKOFF_WIN) || (wr_idx == `IDX_EXP_UNICAST) ||
    (wr_idx == `IDX_UNICAST_VAL) || (wr_idx == `IDX_SHORT_LO) ||
    (wr_idx == `IDX_SHORT_HI) || (wr_idx == `IDX_NETID_LO) ||
    (wr_idx == `IDX_NETID_HI) || (wr_idx == `IDX_CTRL) ||
    (wr_idx == `IDX_STATUS);

  // ************************************************************
  // register storage
  // ************************************************************
  logic [7:0] timeout_q;
  logic [7:0] win_q;
  logic [7:0] exp_q;
  logic [7:0] csma0_q;
  logic [7:0] short_lo_q;
  logic [7:0] short_hi_q;
  logic [7:0] net_lo_q;
  logic [7:0] net_hi_q;

  // timeout select register, only bit 0 kept
  cfg_byte_reg #(.RESET_VAL(`RST_TIMEOUT_MODE),
    .WMASK(`MASK_TIMEOUT_MODE)) u_timeout (
    .aclk(aclk), .aresetn(aresetn), .wr_en(we_timeout),
    .wr_data(wr_data[7:0]), .q(timeout_q));
  // count limit and window, reset 0x20
  cfg_byte_reg #(.RESET_VAL(`RST_BACKOFF_WIN),
    .WMASK(`MASK_BACKOFF_WIN)) u_win (
    .aclk(aclk), .aresetn(aresetn), .wr_en(we_win),
    .wr_data(wr_data[7:0]), .q(win_q));
  // exponent ceiling, zero-exp cca, unicast enable, reset 0x05
  cfg_byte_reg #(.RESET_VAL(`RST_EXP_UNICAST),
    .WMASK(`MASK_EXP_UNICAST)) u_exp (
    .aclk(aclk), .aresetn(aresetn), .wr_en(we_exp),
    .wr_data(wr_data[7:0]), .q(exp_q));
  // unicast value bit only; other csma0 bits live elsewhere
  cfg_byte_reg #(.RESET_VAL(`RST_CSMA0),
    .WMASK(`MASK_CSMA0)) u_csma0 (
    .aclk(aclk), .aresetn(aresetn), .wr_en(we_csma0),
    .wr_data(wr_data[7:0]), .q(csma0_q));
  // short address bytes, reset all ones
  cfg_byte_reg #(.RESET_VAL(8'(`RST_SHORT)),
    .WMASK(8'hFF)) u_short_lo (
    .aclk(aclk), .aresetn(aresetn), .wr_en(we_short_lo),
    .wr_data(wr_data[7:0]), .q(short_lo_q));
  cfg_byte_reg #(.RESET_VAL(8'(`RST_SHORT >> 8)),
    .WMASK(8'hFF)) u_short_hi (
    .aclk(aclk), .aresetn(aresetn), .wr_en(we_short_hi),
    .wr_data(wr_data[7:0]), .q(short_hi_q));
  // network identifier bytes, reset all ones
  cfg_byte_reg #(.RESET_VAL(8'(`RST_NETID)),
    .WMASK(8'hFF)) u_net_lo (
    .aclk(aclk), .aresetn(aresetn), .wr_en(we_net_lo),
    .wr_data(wr_data[7:0]), .q(net_lo_q));
  cfg_byte_reg #(.RESET_VAL(8'(`RST_NETID >> 8)),
    .WMASK(8'hFF)) u_net_hi (
    .aclk(aclk), .aresetn(aresetn), .wr_en(we_net_hi),
    .wr_data(wr_data[7:0]), .q(net_hi_q));

  // ************************************************************
  // csma start bit
  // ************************************************************
  logic go_reg;
  logic go_next;
  // writing 1 sets; writing 0 does nothing; completion clears.
  // a set in the completion cycle wins so a new start is not lost
  wire go_set = we_ctrl && wr_data[`BIT_AUTO_GO];
  assign go_next = go_set ? 1'b1 : (csma_done ? 1'b0 : go_reg);

  // start bit storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_reg <= 1'b0;
    end else begin
      go_reg <= go_next;
    end
  end

  // ************************************************************
  // field outputs
  // ************************************************************
  wire rx_timeout_sel = timeout_q[`BIT_TIMEOUT_SEL];
  // timeout variant only while auto receive mode 0 is enabled
  assign rx_timeout_active = rx_timeout_sel && auto_rx_mode0_en;

  assign csma_param.backoff_count_limit = win_q[`FLD_COUNT_HI:0];
  assign csma_param.contention_window =
    win_q[`FLD_WIN_HI:`FLD_WIN_LO];
  assign csma_param.backoff_exp_ceiling = exp_q[`FLD_EXP_HI:0];
  assign csma_param.zero_exp_cca_sel = exp_q[`BIT_ZERO_EXP_CCA];
  assign csma_param.unicast_value_enable = exp_q[`BIT_UNICAST_EN];
  assign csma_param.unicast_value = csma0_q[`BIT_UNICAST_VAL];
  // disabled handling forces the effective value to zero
  assign csma_param.unicast_eff = exp_q[`BIT_UNICAST_EN] &&
    csma0_q[`BIT_UNICAST_VAL];
  assign csma_param.auto_csma_go = go_reg;
  assign filter_cfg.filter_network_id = {net_hi_q, net_lo_q};
  assign filter_cfg.filter_short_addr = {short_hi_q, short_lo_q};

  // cca decision for the zero floor case
  zero_exp_cca #(.EXP_W(EXP_W)) u_cca (
    .backoff_exp_floor(backoff_exp_floor),
    .zero_exp_cca_sel(exp_q[`BIT_ZERO_EXP_CCA]),
    .cca_do(cca_required));

  // ************************************************************
  // write response
  // ************************************************************
  // hold halves of a write until both have arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      aw_held_reg <= aw_have && !wr_go;
      w_held_reg <= w_have && !wr_go;
      if (aw_fire) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // response one cycle after both halves; unmapped gets slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ************************************************************
  // read path
  // ************************************************************
  assign s_axi_arready = (rd_phase_reg == ph_idle);
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire [15:0] rd_idx = 16'(s_axi_araddr[ADDR_W-1:2]);
  // status word: the start bit as the engine sees it
  wire [7:0] status_q = {7'h00, go_reg};
  logic [7:0] rd_byte;
  logic rd_hit;

  // read mux; fixed-zero bits come out as stored zeros
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (rd_idx)
      `IDX_TIMEOUT_MODE: rd_byte = timeout_q;
      `IDX_BACKOFF_WIN: rd_byte = win_q;
      `IDX_EXP_UNICAST: rd_byte = exp_q;
      `IDX_UNICAST_VAL: rd_byte = csma0_q;
      `IDX_SHORT_LO: rd_byte = short_lo_q;
      `IDX_SHORT_HI: rd_byte = short_hi_q;
      `IDX_NETID_LO: rd_byte = net_lo_q;
      `IDX_NETID_HI: rd_byte = net_hi_q;
      `IDX_CTRL: rd_byte = 8'h00; // start bit is write-only
      `IDX_STATUS: rd_byte = status_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // read phase machine: one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_phase_reg <= ph_idle;
      rdata_reg <= '0;
      rresp_reg <= `RESP_OKAY;
    end else begin
      case (rd_phase_reg)
        ph_idle: begin
          if (ar_fire) begin
            rd_phase_reg <= ph_resp;
            rdata_reg <= {24'h000000, rd_byte};
            rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        ph_resp: begin
          if (s_axi_rready) begin
            rd_phase_reg <= ph_idle;
          end
        end
        default: rd_phase_reg <= ph_idle;
      endcase
    end
  end
  assign s_axi_rvalid = (rd_phase_reg == ph_resp);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule // csma_addr_filter_config_regs

/* File: csma_cfg_defines.svh */
// constants of the csma and address filter configuration bank
// assumes aclk domain; included by the package and the test bench module
`ifndef CSMA_CFG_DEFINES_SVH
`define CSMA_CFG_DEFINES_SVH

// ************************************************************
// register indexes (printed offsets, byte address = index * 4)
// ************************************************************
`define IDX_TIMEOUT_MODE 16'h0011
`define IDX_BACKOFF_WIN 16'h0012
`define IDX_EXP_UNICAST 16'h0013
`define IDX_SHORT_LO 16'h0016
`define IDX_SHORT_HI 16'h0017
`define IDX_NETID_LO 16'h0014
`define IDX_NETID_HI 16'h0015
`define IDX_UNICAST_VAL 16'h000D
`define IDX_CTRL 16'h0020
`define IDX_STATUS 16'h0021

// ************************************************************
// reset values
// ************************************************************
`define RST_TIMEOUT_MODE 8'h00
`define RST_BACKOFF_WIN 8'h20
`define RST_EXP_UNICAST 8'h05
`define RST_SHORT 16'hFFFF
`define RST_NETID 16'hFFFF
`define RST_CSMA0 8'h00

// ************************************************************
// writable bit masks of each byte register
// ************************************************************
`define MASK_TIMEOUT_MODE 8'h01
`define MASK_BACKOFF_WIN 8'h37
`define MASK_EXP_UNICAST 8'h3F
`define MASK_CSMA0 8'h10
`define MASK_CTRL 8'h01

// ************************************************************
// field positions
// ************************************************************
`define BIT_TIMEOUT_SEL 0
`define BIT_UNICAST_VAL 4
`define BIT_AUTO_GO 0
`define FLD_COUNT_HI 2
`define FLD_WIN_HI 5
`define FLD_WIN_LO 4
`define FLD_EXP_HI 3
`define BIT_ZERO_EXP_CCA 4
`define BIT_UNICAST_EN 5

// ************************************************************
// axi responses
// ************************************************************
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: csma_cfg_pkg.sv */
// types of the csma and address filter configuration bank
// assumes the defines header sits in the same folder
package csma_cfg_pkg;
  `include "csma_cfg_defines.svh"

  // csma-ca parameters handed to the csma engine
  typedef struct packed {
    logic [2:0] backoff_count_limit;
    logic [1:0] contention_window;
    logic [3:0] backoff_exp_ceiling;
    logic zero_exp_cca_sel;
    logic unicast_value_enable;
    logic unicast_value;
    logic unicast_eff;
    logic auto_csma_go;
  } csma_param_t;

  // first address filter match conditions
  typedef struct packed {
    logic [15:0] filter_network_id;
    logic [15:0] filter_short_addr;
  } filter_cfg_t;

  // bus slave phases
  typedef enum logic [1:0] {
    ph_idle,
    ph_resp
  } bus_phase_t;
endpackage

/* File: cfg_byte_reg.sv */
// one byte of configuration storage with writable-bit mask
// assumes aclk domain, synchronous active low reset
`timescale 1ns/100ps
module cfg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);
  logic [7:0] q_reg;
  logic [7:0] q_next;

  // fixed-zero bits ignore writes and read back zero
  assign q_next = wr_en ? (wr_data & WMASK) : q_reg;
  assign q = q_reg;

  // storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= RESET_VAL & WMASK;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule // cfg_byte_reg

/* File: zero_exp_cca.sv */
// decides whether the csma engine runs cca for an exponent
// assumes combinational use inside the aclk domain
`timescale 1ns/100ps
module zero_exp_cca #(
  parameter int EXP_W = 3
) (
  input wire logic [EXP_W-1:0] backoff_exp_floor,
  input wire logic zero_exp_cca_sel,
  output logic cca_do
);
  // a zero floor skips cca unless the select bit asks for it
  assign cca_do = (backoff_exp_floor != '0) | zero_exp_cca_sel;
endmodule // zero_exp_cca

/* File: csma_addr_filter_config_regs_asserts.sv */
// concurrent checks of the csma and address filter configuration bank
// assumes a bind onto the top module; sees only its ports
`timescale 1ns/100ps
module csma_addr_filter_config_regs_asserts
  import csma_cfg_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int EXP_W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [EXP_W-1:0] backoff_exp_floor,
  input wire logic csma_done,
  input wire logic auto_rx_mode0_en,
  input wire logic rx_timeout_active,
  input wire logic cca_required,
  input wire csma_param_t csma_param,
  input wire filter_cfg_t filter_cfg
);
  // ************************************************************
  // clocking and bus steps
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence wr_take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // a completed write shows as the rise of bvalid
  sequence wr_done_s;
    $rose(s_axi_bvalid);
  endsequence

  // ************************************************************
  // field outputs
  // ************************************************************
  tmo_gate_a: assert property (!auto_rx_mode0_en |-> !rx_timeout_active)
    else $error("timeout receive active without mode 0");
  cca_select_a: assert property (cca_required ==
    (backoff_exp_floor != '0 || csma_param.zero_exp_cca_sel))
    else $error("cca decision wrong");
  unicast_gate_a: assert property (csma_param.unicast_eff ==
    (csma_param.unicast_value_enable && csma_param.unicast_value))
    else $error("unicast value applied while disabled");
  // guard against values held over from before a reset
  filter_change_a: assert property ($past(aresetn) &&
    $changed(filter_cfg) |-> wr_done_s)
    else $error("filter config changed without a write");
  go_clear_a: assert property ($past(aresetn) &&
    $fell(csma_param.auto_csma_go) |-> $past(csma_done))
    else $error("start bit cleared without completion");
  go_set_a: assert property ($past(aresetn) &&
    $rose(csma_param.auto_csma_go) |-> wr_done_s)
    else $error("start bit set without a write");
  reset_value_a: assert property ($rose(aresetn) |->
    csma_param.contention_window == 2'h2 &&
    csma_param.backoff_count_limit == 3'h0 &&
    csma_param.backoff_exp_ceiling == 4'h5 && filter_cfg == 32'hFFFFFFFF)
    else $error("reset values wrong");

  // ************************************************************
  // bus behaviour
  // ************************************************************
  wr_answer_a: assert property (wr_take_s |=> s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
    else $error("read answer late");
  rd_upper_zero_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  busy_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
endmodule // csma_addr_filter_config_regs_asserts

/* File: csma_addr_filter_config_regs_test.sv */
// self-checking bench of the csma and address filter configuration bank
// assumes the package, defines header and checker in the same folder
`timescale 1ns/100ps
`include "csma_cfg_defines.svh"
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end
module csma_addr_filter_config_regs_test
  import csma_cfg_pkg::*;
;
  // ************************************************************
  // byte addresses, index times four
  // ************************************************************
  localparam logic [7:0] A_TMO = 8'h44, A_WIN = 8'h48, A_EXP = 8'h4C;
  localparam logic [7:0] A_UNI = 8'h34, A_NLO = 8'h50, A_NHI = 8'h54;
  localparam logic [7:0] A_SLO = 8'h58, A_SHI = 8'h5C, A_CTL = 8'h80;
  localparam logic [7:0] A_STS = 8'h84, A_BAD = 8'hFC;
  localparam logic [1:0] OK = `RESP_OKAY, ERR = `RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_timeout_active, cca_required;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] backoff_exp_floor = 3'h0;
  logic csma_done = 1'b0, auto_rx_mode0_en = 1'b0;
  csma_param_t csma_param;
  filter_cfg_t filter_cfg;
  int num_errors = 0, check_count = 0;

  always #2.5 aclk = ~aclk; // 200 MHz

  csma_addr_filter_config_regs #(.ADDR_W(8), .EXP_W(3))
    csma_addr_filter_config_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .backoff_exp_floor(backoff_exp_floor),
    .csma_done(csma_done), .auto_rx_mode0_en(auto_rx_mode0_en),
    .rx_timeout_active(rx_timeout_active), .cca_required(cca_required),
    .csma_param(csma_param), .filter_cfg(filter_cfg));

  // ************************************************************
  // bus tasks, entered just after a rising edge
  // ************************************************************
  // offers both halves together, releases each when taken
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
    // one edge apart, so a next write never re-raises bready at once
    @(posedge aclk);
  endtask
  // rready comes one cycle late so the slave must hold its answer
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    `CHK(csma_param.contention_window, 2'h2)
    `CHK(csma_param.backoff_count_limit, 3'h0)
    `CHK(csma_param.backoff_exp_ceiling, 4'h5)
    `CHK(csma_param.unicast_value_enable, 1'b0)
    `CHK(filter_cfg.filter_network_id, 16'hFFFF)
    `CHK(filter_cfg.filter_short_addr, 16'hFFFF)
    rd(A_WIN, 32'h20, OK);
    rd(A_EXP, 32'h05, OK);
    rd(A_TMO, 32'h00, OK);
    rd(A_SHI, 32'hFF, OK);
  endtask
  // 0xFD and 0xCE written: fixed-zero bits must drop out
  task automatic t_fields;
    wr(A_WIN, 8'hFD, OK);
    `CHK(csma_param.backoff_count_limit, 3'h5)
    rd(A_WIN, 32'h35, OK);
    wr(A_WIN, 8'h10, OK);
    `CHK(csma_param.contention_window, 2'h1)
    wr(A_EXP, 8'hCE, OK);
    `CHK(csma_param.backoff_exp_ceiling, 4'hE)
    rd(A_EXP, 32'h0E, OK);
  endtask
  task automatic t_timeout;
    wr(A_TMO, 8'hFF, OK);
    rd(A_TMO, 32'h01, OK);
    `CHK(rx_timeout_active, 1'b0)
    auto_rx_mode0_en <= 1'b1;
    @(posedge aclk);
    `CHK(rx_timeout_active, 1'b1)
    wr(A_TMO, 8'h00, OK);
    `CHK(rx_timeout_active, 1'b0)
  endtask
  // every floor against both select settings
  task automatic t_cca;
    for (int s = 0; s < 2; s++) begin
      wr(A_EXP, {3'h0, s[0], 4'hE}, OK);
      `CHK(csma_param.zero_exp_cca_sel, s[0])
      for (int f = 0; f < 8; f++) begin
        backoff_exp_floor <= 3'(f);
        @(posedge aclk);
        `CHK(cca_required, logic'(f != 0 || s != 0))
      end
    end
    // floor back to zero so later ceilings of 5 stay above it
    backoff_exp_floor <= 3'h0;
  endtask
  task automatic t_unicast;
    for (int v = 0; v < 2; v++) begin
      for (int e = 0; e < 2; e++) begin
        wr(A_UNI, v[0] ? 8'hFF : 8'h00, OK);
        wr(A_EXP, e[0] ? 8'h25 : 8'h05, OK);
        `CHK(csma_param.unicast_value, v[0])
        `CHK(csma_param.unicast_eff, v[0] & e[0])
      end
    end
    rd(A_UNI, 32'h10, OK);
  endtask
  // an unmapped write must leave the filter alone
  task automatic t_filter;
    wr(A_NLO, 8'h34, OK);
    wr(A_NHI, 8'h12, OK);
    wr(A_SLO, 8'hCD, OK);
    wr(A_SHI, 8'hAB, OK);
    wr(A_BAD, 8'h00, ERR);
    rd(A_BAD, 32'h00, ERR);
    `CHK(filter_cfg.filter_network_id, 16'h1234)
    `CHK(filter_cfg.filter_short_addr, 16'hABCD)
  endtask
  // writing zero must not clear a running start
  task automatic t_go;
    wr(A_CTL, 8'h01, OK);
    rd(A_STS, 32'h01, OK);
    wr(A_CTL, 8'h00, OK);
    `CHK(csma_param.auto_csma_go, 1'b1)
    csma_done <= 1'b1;
    @(posedge aclk);
    csma_done <= 1'b0;
    @(posedge aclk);
    `CHK(csma_param.auto_csma_go, 1'b0)
  endtask

  // ************************************************************
  // verdict and run control
  // ************************************************************
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_fields();
    t_timeout();
    t_cca();
    t_unicast();
    t_filter();
    t_go();
    close_out();
  end
  // whole run needs well under a few thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    close_out();
  end
endmodule // csma_addr_filter_config_regs_test

bind csma_addr_filter_config_regs csma_addr_filter_config_regs_asserts
  #(.ADDR_W(ADDR_W), .EXP_W(EXP_W)) asserts_inst (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .backoff_exp_floor(backoff_exp_floor), .csma_done(csma_done),
  .auto_rx_mode0_en(auto_rx_mode0_en),
  .rx_timeout_active(rx_timeout_active), .cca_required(cca_required),
  .csma_param(csma_param), .filter_cfg(filter_cfg));
